// *** port_six_cfg.svh ***
/*
 * Register addresses, reset values and bit positions of the four-pin port.
 * Assumes a 20-bit register address and an 8-bit register data path.
 */
`ifndef PORT_SIX_CFG_SVH
`define PORT_SIX_CFG_SVH

// Register addresses
`define PIN_DIR_ADDR      20'hEE005
`define PIN_VAL_ADDR      20'hFFFD5

// Reset and hardware standby load value of both registers
`define PORT_RESET_VAL    8'h80

// Constant read values
`define DIR_READ_VAL      8'hFF
`define UNDEF_READ_VAL    4'h0
`define IDLE_READ_VAL     8'h00

// Bit positions
`define TOP_BIT           7
`define SPARE_HI          6
`define SPARE_LO          3
`define PIN_TWO_BIT       2
`define PIN_ONE_BIT       1
`define PIN_ZERO_BIT      0

`endif

// *** port_six_pkg.sv ***
/*
 * Types shared by the four-pin port and its surroundings.
 * Assumes the register map constants of port_six_cfg.svh.
 */
package port_six_pkg;

    // Register port request: one strobe at a time
    typedef struct packed {
        logic [19:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // Drive of the three bidirectional pins
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } pin_drv_t;

endpackage

// *** four_pin_port.sv ***
/*
 * Four-pin general-purpose port with shared clock output, bus release and
 * wait functions: direction and value registers, pin multiplexing, read-back.
 * Assumes the register master, the bus controller and the power-down logic
 * run on mclk; the pads apply the enables and drive the clock image.
 */
// Overview of operation
// - The port has a top pin at bit 7 that is input or clock output, and three two-way pins 2..0.
// - Direction bit 7 is always one and ignores writes, and bits 7..3 never steer a pin.
// - The top pin drives the system clock while the clock stop bit is 0, else it is an input.
// - As ordinary pins, pins 2..0 drive their value bit when the direction bit is 1, else float.
// - The direction register is write-only and always reads as all ones.
// - Reset and hardware standby load the direction register with 80h; software standby keeps it.
// - In software standby a port pin with its direction bit at 1 keeps driving its level.
// - A pin acting as ordinary output drives the matching value register bit.
// - Value bit 7 ignores writes and reads 1 with the clock running, or the top pin level if stopped.
// - Value bits 6..3 reach no pin and read the stored value when the direction bit is 1, else 0.
// - Value bits 2..0 read the pin level when the direction bit is 0, else the stored value.
// - Reset and hardware standby load the value register with 80h; software standby keeps it.
// - With bus release enabled, pin two is the acknowledge output and pin one the request input.
`include "port_six_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module four_pin_port (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    hw_standby,
    input  wire port_six_pkg::reg_req_t  reg_req,
    output logic [7:0]                   reg_rdata,
    input  wire logic                    clock_out_stop,
    input  wire logic                    bus_release_enable,
    input  wire logic                    wait_pin_enable,
    input  wire logic                    bus_ack_n,
    output logic                         bus_request_n,
    output logic                         wait_n,
    input  wire logic                    top_pin_in,
    output logic                         top_pin_clk_en,
    output logic                         top_pin_oe,
    input  wire logic [2:0]              pin_in,
    output port_six_pkg::pin_drv_t       pin_drv
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    logic       load_init;

    // Pins are asynchronous; only the second stage is ever looked at
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_meta_r <= 4'hF;
            pin_sync_r <= 4'hF;
        end else begin
            pin_meta_r <= {top_pin_in, pin_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign load_init = rst | hw_standby;

    // ************************************************************
    // Register decode
    // ************************************************************
    logic dir_hit;
    logic val_hit;

    assign dir_hit = (reg_req.addr == `PIN_DIR_ADDR);
    assign val_hit = (reg_req.addr == `PIN_VAL_ADDR);

    // ************************************************************
    // Direction register
    // ************************************************************
    logic [6:0] dir_r;
    logic [7:0] dir_full;

    // Bit seven has no storage, so only the low seven bits of the load value are kept
    localparam logic [7:0] init_load_val = `PORT_RESET_VAL;

    // initial load on reset
    // Software standby has no input here: contents simply hold
    always_ff @(posedge mclk) begin
        if (load_init) begin
            dir_r <= init_load_val[6:0];
        end else if (reg_req.wr && dir_hit) begin
            dir_r <= reg_req.wdata[6:0];
        end
    end

    assign dir_full = {1'b1, dir_r};

    // ************************************************************
    // Value register
    // ************************************************************
    logic [6:0] val_r;

    // bit seven has no storage, writes to it vanish
    always_ff @(posedge mclk) begin
        if (load_init) begin
            val_r <= init_load_val[6:0];
        end else if (reg_req.wr && val_hit) begin
            val_r <= reg_req.wdata[6:0];
        end
    end

    // ************************************************************
    // Read-back
    // ************************************************************
    logic [7:0] val_read;
    logic [7:0] rdata_nxt;

    always_comb begin
        val_read = 8'h00;
        val_read[`TOP_BIT] = clock_out_stop ? pin_sync_r[3] : 1'b1;
        // spare bits, undefined read as zero
        for (int i = `SPARE_LO; i <= `SPARE_HI; i++) begin
            val_read[i] = dir_r[i] ? val_r[i] : 1'b0;
        end
        for (int i = `PIN_ZERO_BIT; i <= `PIN_TWO_BIT; i++) begin
            val_read[i] = dir_r[i] ? val_r[i] : pin_sync_r[i];
        end
    end

    always_comb begin
        rdata_nxt = `IDLE_READ_VAL;
        if (reg_req.rd) begin
            if (dir_hit) begin
                rdata_nxt = `DIR_READ_VAL;
            end else if (val_hit) begin
                rdata_nxt = val_read;
            end
        end
    end

    // Read data stand for exactly one cycle, zero otherwise
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= `IDLE_READ_VAL;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // ************************************************************
    // Pin multiplexing
    // ************************************************************
    port_six_pkg::pin_drv_t drv_nxt;

    always_comb begin
        drv_nxt.oe  = dir_r[2:0];
        drv_nxt.out = val_r[2:0];
        // bus release takes pins two and one
        if (bus_release_enable) begin
            drv_nxt.oe[`PIN_TWO_BIT]  = 1'b1;
            drv_nxt.out[`PIN_TWO_BIT] = bus_ack_n;
            drv_nxt.oe[`PIN_ONE_BIT]  = 1'b0;
            drv_nxt.out[`PIN_ONE_BIT] = 1'b0;
        end
        if (wait_pin_enable) begin
            drv_nxt.oe[`PIN_ZERO_BIT]  = 1'b0;
            drv_nxt.out[`PIN_ZERO_BIT] = 1'b0;
        end
    end

    // drive holds through software standby
    // One cycle of latency keeps every pin output glitch free
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_drv <= '0;
        end else begin
            pin_drv <= drv_nxt;
        end
    end

    // clock out unless stopped
    // The pad gates mclk with this enable; a flop cannot carry the clock
    always_ff @(posedge mclk) begin
        if (rst) begin
            top_pin_clk_en <= 1'b1;
            top_pin_oe     <= 1'b1;
        end else begin
            top_pin_clk_en <= ~clock_out_stop;
            top_pin_oe     <= ~clock_out_stop;
        end
    end

    // ************************************************************
    // Alternate function inputs
    // ************************************************************
    // request from pin one
    // wait from pin zero
    // Disabled functions report the inactive high level
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_request_n <= 1'b1;
            wait_n        <= 1'b1;
        end else begin
            bus_request_n <= bus_release_enable ? pin_sync_r[`PIN_ONE_BIT] : 1'b1;
            wait_n        <= wait_pin_enable ? pin_sync_r[`PIN_ZERO_BIT] : 1'b1;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_DIR_READ_ONES: assert property (
        @(posedge mclk) disable iff (rst)
        (reg_req.rd && dir_hit) |=> (reg_rdata == `DIR_READ_VAL))
    else $error("Direction register read did not return all ones");

    AST_DIR_BIT7_HIGH: assert property (
        @(posedge mclk) disable iff (rst)
        (reg_req.wr && dir_hit && !hw_standby) |=> (dir_full[`TOP_BIT] == 1'b1)
            && (dir_r == $past(reg_req.wdata[6:0])))
    else $error("Direction write stored wrongly or bit seven dropped");

    AST_INIT_LOAD: assert property (
        @(posedge mclk)
        (rst || hw_standby) |=> (dir_r == 7'h00) && (val_r == 7'h00))
    else $error("Registers not reloaded by reset or hardware standby");

    AST_VAL_WRITE: assert property (
        @(posedge mclk) disable iff (rst)
        (reg_req.wr && val_hit && !hw_standby) ##1 (reg_req.rd && val_hit && dir_r[5])
            |=> (reg_rdata[5] == $past(reg_req.wdata[5], 2)))
    else $error("Spare value bit did not read back written data");

    AST_TOP_READ: assert property (
        @(posedge mclk) disable iff (rst)
        (reg_req.rd && val_hit)
            |=> (reg_rdata[`TOP_BIT] == ($past(clock_out_stop) ? $past(pin_sync_r[3]) : 1'b1)))
    else $error("Top value bit read wrong");

    AST_SPARE_UNDEF: assert property (
        @(posedge mclk) disable iff (rst)
        (reg_req.rd && val_hit && !dir_r[4]) |=> (reg_rdata[4] == 1'b0))
    else $error("Spare bit with direction zero did not read as zero");

    AST_PIN_READ: assert property (
        @(posedge mclk) disable iff (rst)
        (reg_req.rd && val_hit && !dir_r[2]) |=> (reg_rdata[2] == $past(pin_sync_r[2])))
    else $error("Input pin level not returned on read");

    AST_IDLE_RDATA: assert property (
        @(posedge mclk) disable iff (rst)
        !reg_req.rd |=> (reg_rdata == `IDLE_READ_VAL))
    else $error("Read data stood beyond its cycle");

    AST_PORT_OUT: assert property (
        @(posedge mclk) disable iff (rst)
        (!bus_release_enable && dir_r[1])
            |=> pin_drv.oe[1] && (pin_drv.out[1] == $past(val_r[1])))
    else $error("Ordinary output pin not driving its value bit");

    AST_PORT_IN: assert property (
        @(posedge mclk) disable iff (rst)
        (!wait_pin_enable && !dir_r[0]) |=> !pin_drv.oe[0])
    else $error("Ordinary input pin is driven");

    AST_ACK_PIN: assert property (
        @(posedge mclk) disable iff (rst)
        bus_release_enable
            |=> pin_drv.oe[2] && !pin_drv.oe[1] && (pin_drv.out[2] == $past(bus_ack_n)))
    else $error("Bus release pins not taken by the alternate function");

    AST_REQ_FOLLOW: assert property (
        @(posedge mclk) disable iff (rst)
        !bus_release_enable |=> bus_request_n)
    else $error("Bus request active while release disabled");

    AST_WAIT_PIN: assert property (
        @(posedge mclk) disable iff (rst)
        wait_pin_enable |=> !pin_drv.oe[0] && (wait_n == $past(pin_sync_r[0])))
    else $error("Wait pin driven or wait level not passed on");

    AST_ALT_ONLY: assert property (
        @(posedge mclk) disable iff (rst)
        (bus_release_enable && dir_r[1]) |=> !pin_drv.oe[1])
    else $error("Direction bit reached a pin in alternate function");

    AST_CLK_OUT: assert property (
        @(posedge mclk) disable iff (rst)
        clock_out_stop |=> !top_pin_oe && !top_pin_clk_en)
    else $error("Top pin still drives clock while stopped");

    AST_HOLD_DRIVE: assert property (
        @(posedge mclk) disable iff (rst)
        ($stable(dir_r) && $stable(val_r) && !bus_release_enable && !wait_pin_enable)
            ##1 ($stable(dir_r) && $stable(val_r) && !bus_release_enable && !wait_pin_enable)
            |=> $stable(pin_drv))
    else $error("Pin drive changed with registers steady");

    AST_TOP_PIN_KIND: assert property (
        @(posedge mclk) disable iff (rst)
        !clock_out_stop |=> top_pin_oe)
    else $error("Top pin not driving clock while running");

    AST_VAL_INIT: assert property (
        @(posedge mclk) disable iff (rst)
        hw_standby |=> (val_r == 7'h00))
    else $error("Value register not cleared by hardware standby");

endmodule

`default_nettype wire

// *** pin_partner.sv ***
/*
 * Far side of the four-pin port: the board wiring of the pins.
 * Assumes the bench sets the levels that outside parties would drive.
 */
`timescale 1ns/100ps
`default_nettype none

module pin_partner (
    input  wire logic                    mclk,
    input  wire port_six_pkg::pin_drv_t  pin_drv,
    input  wire logic [2:0]              ext_lvl,
    input  wire logic                    top_clk_en,
    input  wire logic                    top_oe,
    input  wire logic                    ext_top,
    output logic [2:0]                   pin_in,
    output logic                         top_pin_in
);
    // ************************************************
    // Wire resolution
    // ************************************************
    // driver wins the wire
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_in[i] = pin_drv.oe[i] ? pin_drv.out[i] : ext_lvl[i];
        end
    end
    assign top_pin_in = (top_oe && top_clk_en) ? mclk : ext_top;
endmodule
`default_nettype wire

// *** test_four_pin_port.sv ***
/*
 * Self-checking bench of the four-pin port: register accesses and pin checks.
 * Assumes pin_partner resolves the pin levels; software standby has no port.
 */
`include "port_six_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module test_four_pin_port;
    logic                   mclk = 1'b0;
    logic                   rst = 1'b1;
    logic                   hw_standby = 1'b0;
    port_six_pkg::reg_req_t reg_req = '0;
    logic [7:0]             reg_rdata;
    logic                   clock_out_stop = 1'b0;
    logic                   bus_release_enable = 1'b0;
    logic                   wait_pin_enable = 1'b0;
    logic                   bus_ack_n = 1'b1;
    logic                   bus_request_n;
    logic                   wait_n;
    logic                   top_pin_in;
    logic                   top_pin_clk_en;
    logic                   top_pin_oe;
    logic [2:0]             pin_in;
    port_six_pkg::pin_drv_t pin_drv;
    logic [2:0]             ext_lvl = 3'h5;
    logic                   ext_top = 1'b0;
    int                     fails = 0;
    int                     n_tests = 0;

    always #2.5 mclk = ~mclk;

    four_pin_port four_pin_port_i (.mclk(mclk), .rst(rst), .hw_standby(hw_standby),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .clock_out_stop(clock_out_stop),
        .bus_release_enable(bus_release_enable), .wait_pin_enable(wait_pin_enable),
        .bus_ack_n(bus_ack_n), .bus_request_n(bus_request_n), .wait_n(wait_n),
        .top_pin_in(top_pin_in), .top_pin_clk_en(top_pin_clk_en),
        .top_pin_oe(top_pin_oe), .pin_in(pin_in), .pin_drv(pin_drv));

    pin_partner pin_partner_i (.mclk(mclk), .pin_drv(pin_drv), .ext_lvl(ext_lvl),
        .top_clk_en(top_pin_clk_en), .top_oe(top_pin_oe), .ext_top(ext_top),
        .pin_in(pin_in), .top_pin_in(top_pin_in));

    // ************************************************
    // Access tasks
    // ************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.wr <= 1'b1;
        @(posedge mclk);
        reg_req.wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [19:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // Write then read in the very next cycle, with no gap between strobes
    task automatic wr_rd(input logic [19:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge mclk);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.wr <= 1'b1;
        @(posedge mclk);
        reg_req.wr <= 1'b0;
        reg_req.rd <= 1'b1;
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // Settling span covers the two-flop synchroniser and the output flop
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #20000;
        fails++;
        stop_test();
    end

    // ************************************************
    // Test sequence
    // ************************************************
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        idle(1);
        chk({top_pin_clk_en, top_pin_oe, pin_drv}, 8'hC0);
        rd(`PIN_DIR_ADDR, 8'hFF);
        rd(`PIN_VAL_ADDR, 8'h85);
        wr(`PIN_VAL_ADDR, 8'h2A);
        wr(`PIN_DIR_ADDR, 8'h07);
        idle(2);
        chk({2'h0, pin_drv}, 8'h17);
        rd(`PIN_VAL_ADDR, 8'h82);
        wr(`PIN_DIR_ADDR, 8'h7F);
        wr_rd(`PIN_VAL_ADDR, 8'h55, 8'hD5);
        wr_rd(`PIN_VAL_ADDR, 8'h2A, 8'hAA);
        rd(`PIN_VAL_ADDR, 8'hAA);
        rd(`PIN_DIR_ADDR, 8'hFF);
        chk({2'h0, pin_drv}, 8'h17);
        wr(`PIN_DIR_ADDR, 8'h0A);
        // Released pins need the output flop and both synchroniser stages
        idle(4);
        rd(`PIN_VAL_ADDR, 8'h8F);
        // Unmapped places
        wr(20'h00000, 8'hFF);
        rd(`PIN_VAL_ADDR, 8'h8F);
        rd(20'hEE006, 8'h00);
        idle(50);
        chk({2'h0, pin_drv}, 8'h12);
        clock_out_stop <= 1'b1;
        ext_top <= 1'b1;
        idle(4);
        chk({6'h00, top_pin_clk_en, top_pin_oe}, 8'h00);
        rd(`PIN_VAL_ADDR, 8'h8F);
        ext_top <= 1'b0;
        idle(4);
        rd(`PIN_VAL_ADDR, 8'h0F);
        clock_out_stop <= 1'b0;
        idle(2);
        chk({6'h00, top_pin_clk_en, top_pin_oe}, 8'h03);
        // Bus release takes pins two and one
        wr(`PIN_DIR_ADDR, 8'h07);
        bus_release_enable <= 1'b1;
        bus_ack_n <= 1'b0;
        ext_lvl <= 3'h0;
        idle(5);
        chk({2'h0, pin_drv}, 8'h05);
        chk({7'h00, bus_request_n}, 8'h00);
        bus_ack_n <= 1'b1;
        idle(2);
        chk({2'h0, pin_drv}, 8'h25);
        bus_release_enable <= 1'b0;
        idle(5);
        chk({2'h0, pin_drv}, 8'h17);
        chk({7'h00, bus_request_n}, 8'h01);
        // direction bit of pin zero kept at 0
        wr(`PIN_DIR_ADDR, 8'h06);
        wait_pin_enable <= 1'b1;
        idle(5);
        chk({7'h00, wait_n}, 8'h00);
        chk({2'h0, pin_drv}, 8'h16);
        ext_lvl <= 3'h1;
        idle(5);
        chk({7'h00, wait_n}, 8'h01);
        wait_pin_enable <= 1'b0;
        ext_lvl <= 3'h0;
        idle(5);
        chk({7'h00, wait_n}, 8'h01);
        // Hardware standby reloads both registers
        hw_standby <= 1'b1;
        @(posedge mclk);
        hw_standby <= 1'b0;
        idle(2);
        chk({2'h0, pin_drv}, 8'h00);
        rd(`PIN_DIR_ADDR, 8'hFF);
        rd(`PIN_VAL_ADDR, 8'h80);
        stop_test();
    end
endmodule
`default_nettype wire
